// >>> rtl/csc_pkg.sv
/*
  Package for the clock source and sleep controller: encodings, reset
  values and timing counts. Assumes a single 100 MHz system clock.
*/
package csc_pkg;

  // System clock source encodings
  typedef enum logic [2:0] {
    SRC_RC2M  = 3'h0,
    SRC_RC32M = 3'h1,
    SRC_RC32K = 3'h2,
    SRC_XOSC  = 3'h3,
    SRC_PLL   = 3'h4,
    SRC_WXTAL = 3'h5
  } csc_src_t;

  // Sleep mode encodings
  typedef enum logic [2:0] {
    SLP_IDLE  = 3'h0,
    SLP_PDOWN = 3'h2,
    SLP_PSAVE = 3'h3,
    SLP_STDBY = 3'h6,
    SLP_ESTBY = 3'h7
  } csc_slp_t;

  // Power state machine
  typedef enum logic [1:0] {
    PS_ACTIVE = 2'b00,
    PS_SLEEP  = 2'b01,
    PS_HALT   = 2'b10
  } csc_pst_t;

  // Real-time counter clock choice
  typedef enum logic [1:0] {
    RTC_LDRAIN = 2'h0,
    RTC_RC32K  = 2'h1,
    RTC_WXTAL  = 2'h2
  } csc_rtc_t;

  // Oscillator enable bundle
  typedef struct packed {
    logic rc2m;
    logic rc32m;
    logic rc32k;
    logic xosc;
    logic pll;
    logic wxtal;
  } csc_osc_t;

  // Wake-up request bundle
  typedef struct packed {
    logic anyIrq;
    logic twiAddr;
    logic portAsync;
    logic usbResume;
    logic rtcIrq;
  } csc_wake_t;

  // Gated clock enables
  typedef struct packed {
    logic cpu;
    logic nvm;
    logic per;
    logic rtc;
  } csc_gate_t;

  localparam csc_src_t  SRC_RST     = SRC_RC2M;
  localparam csc_osc_t  OSC_RST     = 6'h20;   // Only the 2 MHz source on
  localparam int        HALT_CYC    = 4;
  localparam logic [4:0] PLL_MIN    = 5'h01;
  localparam logic [4:0] PLL_MAX    = 5'h1F;
  localparam logic [1:0] XOSC_MODES = 2'h3;    // Highest of four range modes
  localparam logic [10:0] PRE_RST   = 11'h000;
  localparam logic [7:0] CAL32K_RST = 8'h80;
  localparam logic [7:0] CAL32M_RST = 8'h80;
  localparam logic [4:0] DIV32_LOG  = 5'h05;   // 32 kHz / 32 gives 1 kHz taps

endpackage

// >>> rtl/csc_clock_sleep_ctrl.sv
/*
  Clock source selection and sleep control for a small controller.
  Assumes the oscillators report stability as levels from outside the
  clock domain and that the CPU signals the sleep instruction as a pulse.
*/
// What this block does
// - Any reset disables all clock sources, the low drain 32k oscillator included, except the 2 MHz oscillator.
// - After reset the system clock always comes from the 2 MHz oscillator.
// - Calibrators and multiplier loop leave reset off until software enables them.
// - Software may change source selection and prescalers at any time.
// - Enabled monitor: crystal or loop failure raises NMI, falls back internally.
// - Low drain oscillator runs only while something uses it; gives 1 kHz.
// - Calibrated 32.768k oscillator gives full and 1.024k outputs, writable trim.
// - Watch crystal serves as system, real-time counter and calibrator reference.
// - Main crystal oscillator offers four selectable frequency range modes.
// - 32 MHz oscillator trims to 30-55 MHz, optionally by calibrator.
// - Multiplier loop factor is an integer from 1 to 31.
// - Sleep entered only from active by sleep instruction, configured mode.
// - Wake interrupt served after higher ones, then resume after sleep.
// - CPU stays halted four cycles after every wake-up.
// - State kept during sleep; reset in sleep restarts from reset vector.
// - Idle stops CPU and memory after programming; any interrupt wakes.
// - Power-down stops all clocks, memory once programming completes; only three asynchronous sources wake.
// - Power-save adds real-time counter running and its wake interrupt.
// - Standby keeps sources oscillating; CPU, peripheral, counter clocks gated.
// - Extended standby is power-save with sources kept oscillating.
// - Power reduction bit stops a peripheral clock in active and idle.
`timescale 1ns/100ps
`default_nettype none

module csc_clock_sleep_ctrl #(
  parameter int NPER = 8
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Source control
  input  wire csc_pkg::csc_src_t    srcSel,
  input  wire csc_pkg::csc_osc_t    oscEnReq,
  input  wire logic [10:0]          prescale,
  input  wire logic [4:0]           pllFactor,
  input  wire logic [1:0]           xoscMode,
  input  wire logic [7:0]           cal32k,
  input  wire logic [7:0]           cal32m,
  input  wire logic                 calib2mEn,
  input  wire logic                 calib32mEn,
  input  wire logic                 calibRefWatch,
  input  wire csc_pkg::csc_rtc_t    rtcSrc,
  input  wire logic                 rtcEn,
  input  wire logic                 wdtEn,
  input  wire logic                 failMonEn,
  // Oscillator status from analog side
  input  wire csc_pkg::csc_osc_t    oscStable,
  input  wire logic                 xoscFail,
  input  wire logic                 pllFail,
  // Sleep control
  input  wire logic                 sleepInstr,
  input  wire logic                 sleepEn,
  input  wire csc_pkg::csc_slp_t    sleepMode,
  input  wire logic                 nvmBusy,
  input  wire csc_pkg::csc_wake_t   wakeReq,
  input  wire logic [NPER-1:0]      powerReduce,
  // Clock outputs and status
  output logic                      lowDrainOn,
  output csc_pkg::csc_osc_t         oscEn,
  output csc_pkg::csc_src_t         sysSrc,
  output logic [10:0]               prescaleOut,
  output logic [4:0]                pllFactorOut,
  output logic [1:0]                xoscModeOut,
  output logic [7:0]                cal32kOut,
  output logic [7:0]                cal32mOut,
  output logic                      calib2mOn,
  output logic                      calib32mOn,
  output logic                      calibRefWatchOut,
  output csc_pkg::csc_rtc_t         rtcSrcOut,
  output logic                      nmiReq,
  output csc_pkg::csc_gate_t        gate,
  output logic [NPER-1:0]           perClkEn,
  output logic                      cpuHalt,
  output logic                      asleep
);
  import csc_pkg::*;

  // Registered outputs
  logic               lowDrainOn_ff;
  csc_osc_t           oscEn_ff;
  csc_src_t           sysSrc_ff;
  logic [10:0]        pre_ff;
  logic [4:0]         pll_ff;
  logic [1:0]         xmode_ff;
  logic [7:0]         c32k_ff;
  logic [7:0]         c32m_ff;
  logic               cal2_ff;
  logic               cal32_ff;
  logic               calRef_ff;
  csc_rtc_t           rtcSrc_ff;
  logic               nmi_ff;
  csc_gate_t          gate_ff;
  logic [NPER-1:0]    perEn_ff;
  logic               halt_ff;
  csc_pst_t           pst_ff;
  logic [2:0]         haltCnt_ff;
  logic               failLatch_ff;
  csc_slp_t           mode_ff;
  logic               asleep_ff;   // Own flop so the sleep flag has no decode glitch

  // Synchronised asynchronous status inputs
  csc_osc_t           stbMeta_ff;
  csc_osc_t           stb_ff;
  logic [1:0]         failMeta_ff;
  logic [1:0]         failSync_ff;
  logic [4:0]         wakeMeta_ff;
  logic [4:0]         wakeSync_ff;

  // Two-flop synchronisers for analog status and asynchronous wake sources
  always_ff @(posedge clk)
  begin
    stbMeta_ff  <= oscStable;
    stb_ff      <= stbMeta_ff;
    failMeta_ff <= {xoscFail, pllFail};
    failSync_ff <= failMeta_ff;
    wakeMeta_ff <= wakeReq;
    wakeSync_ff <= wakeMeta_ff;
  end

  // Stable flag of a given source, used by the switch; the fallback does not check it
  function automatic logic srcStable(csc_src_t s, csc_osc_t st);
    case (s)
      SRC_RC2M:  srcStable = st.rc2m;
      SRC_RC32M: srcStable = st.rc32m;
      SRC_RC32K: srcStable = st.rc32k;
      SRC_XOSC:  srcStable = st.xosc;
      SRC_PLL:   srcStable = st.pll;
      SRC_WXTAL: srcStable = st.wxtal;
      default:   srcStable = 1'b0;
    endcase
  endfunction

  logic failNow;
  logic inStandby;
  assign failNow   = failMonEn && ((failSync_ff[1] && sysSrc_ff == SRC_XOSC) ||
                                   (failSync_ff[0] && sysSrc_ff == SRC_PLL));
  assign inStandby = (pst_ff != PS_ACTIVE) &&
                     (mode_ff == SLP_STDBY || mode_ff == SLP_ESTBY);

  // Oscillator enables; deep sleep drops them unless a standby mode holds them
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      oscEn_ff <= OSC_RST;
    else if (pst_ff == PS_SLEEP && mode_ff != SLP_IDLE && !inStandby)
      oscEn_ff <= '0;
    else
    begin
      oscEn_ff      <= oscEnReq;
      oscEn_ff.rc2m <= oscEnReq.rc2m | (sysSrc_ff == SRC_RC2M) | failLatch_ff;
    end
  end

  // Glitch-free selection: a switch waits for the new source to be stable
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sysSrc_ff <= SRC_RST;
    else if (failNow)
      sysSrc_ff <= SRC_RC2M;
    else if (srcSel != sysSrc_ff && srcStable(srcSel, stb_ff) && !failLatch_ff)
      sysSrc_ff <= srcSel;
  end

  // Failure latch holds the fallback until the monitor is disarmed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      failLatch_ff <= 1'b0;
      nmi_ff       <= 1'b0;
    end
    else
    begin
      failLatch_ff <= failNow | (failLatch_ff & failMonEn);
      nmi_ff       <= failNow;
    end
  end

  // Run-time settings; the loop factor is clamped to its legal range
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre_ff    <= PRE_RST;
      pll_ff    <= PLL_MIN;
      xmode_ff  <= 2'h0;
      c32k_ff   <= CAL32K_RST;
      c32m_ff   <= CAL32M_RST;
      cal2_ff   <= 1'b0;
      cal32_ff  <= 1'b0;
      calRef_ff <= 1'b0;
      rtcSrc_ff <= RTC_LDRAIN;
    end
    else
    begin
      pre_ff    <= prescale;
      pll_ff    <= (pllFactor < PLL_MIN) ? PLL_MIN :
                   (pllFactor > PLL_MAX) ? PLL_MAX : pllFactor;
      xmode_ff  <= (xoscMode > XOSC_MODES) ? XOSC_MODES : xoscMode;
      c32k_ff   <= cal32k;
      c32m_ff   <= cal32m;
      cal2_ff   <= calib2mEn;
      cal32_ff  <= calib32mEn;
      calRef_ff <= calibRefWatch;
      rtcSrc_ff <= rtcSrc;
    end
  end

  // Low drain oscillator runs only while the counter or watchdog uses it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lowDrainOn_ff <= 1'b0;
    else
      lowDrainOn_ff <= wdtEn | (rtcEn & rtcSrc_ff == RTC_LDRAIN);
  end

  // Wake decision per mode; reset in any state returns to active
  logic wakeHit;
  always_comb
  begin
    case (mode_ff)
      SLP_IDLE:  wakeHit = wakeSync_ff[4] | (|wakeSync_ff[3:1]);
      SLP_PSAVE,
      SLP_ESTBY: wakeHit = (|wakeSync_ff[3:1]) | (rtcEn & wakeSync_ff[0]);
      default:   wakeHit = |wakeSync_ff[3:1];
    endcase
  end

  // Power state machine; registers are never cleared by sleep
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pst_ff     <= PS_ACTIVE;
      mode_ff    <= SLP_IDLE;
      haltCnt_ff <= 3'h0;
      halt_ff    <= 1'b0;
      asleep_ff  <= 1'b0;
    end
    else
      case (pst_ff)
        PS_ACTIVE:
        begin
          halt_ff <= 1'b0;
          if (sleepInstr && sleepEn)
          begin
            pst_ff  <= PS_SLEEP;
            mode_ff <= sleepMode;
            halt_ff <= 1'b1;
            asleep_ff <= 1'b1;
          end
        end
        PS_SLEEP:
          if (wakeHit)
          begin
            pst_ff     <= PS_HALT;
            asleep_ff  <= 1'b0;
            haltCnt_ff <= 3'(HALT_CYC - 1);
          end
        PS_HALT:
          if (haltCnt_ff == 3'h0)
          begin
            pst_ff  <= PS_ACTIVE;
            halt_ff <= 1'b0;
          end
          else
            haltCnt_ff <= haltCnt_ff - 3'h1;
        default:
          pst_ff <= PS_ACTIVE;
      endcase
  end

  // Clock gates; idle keeps the memory clock until programming completes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gate_ff  <= 4'hF;
      perEn_ff <= '1;
    end
    else if (pst_ff == PS_ACTIVE && !(sleepInstr && sleepEn))
    begin
      gate_ff  <= 4'hF;
      perEn_ff <= ~powerReduce;
    end
    else if (pst_ff == PS_HALT)
    begin
      gate_ff  <= 4'hF;
      perEn_ff <= ~powerReduce;
    end
    else if ((pst_ff == PS_ACTIVE ? sleepMode : mode_ff) == SLP_IDLE)
    begin
      gate_ff     <= '{cpu: 1'b0, nvm: nvmBusy, per: 1'b1, rtc: 1'b1};
      perEn_ff    <= ~powerReduce;
    end
    else
    begin
      gate_ff.cpu <= 1'b0;
      gate_ff.nvm <= nvmBusy & gate_ff.nvm;
      gate_ff.per <= 1'b0;
      gate_ff.rtc <= rtcEn & ((pst_ff == PS_ACTIVE ? sleepMode : mode_ff) == SLP_PSAVE ||
                     (pst_ff == PS_ACTIVE ? sleepMode : mode_ff) == SLP_ESTBY);
      perEn_ff    <= '0;
    end
  end

  assign lowDrainOn       = lowDrainOn_ff;
  assign oscEn            = oscEn_ff;
  assign sysSrc           = sysSrc_ff;
  assign prescaleOut      = pre_ff;
  assign pllFactorOut     = pll_ff;
  assign xoscModeOut      = xmode_ff;
  assign cal32kOut        = c32k_ff;
  assign cal32mOut        = c32m_ff;
  assign calib2mOn        = cal2_ff;
  assign calib32mOn       = cal32_ff;
  assign calibRefWatchOut = calRef_ff;
  assign rtcSrcOut        = rtcSrc_ff;
  assign nmiReq           = nmi_ff;
  assign gate             = gate_ff;
  assign perClkEn         = perEn_ff;
  assign cpuHalt          = halt_ff;
  assign asleep           = asleep_ff;

endmodule // csc_clock_sleep_ctrl

`default_nettype wire

// >>> bench/csc_osc_model.sv
/* Oscillator side model: reports stability and failures.
   Assumes one clock shared with the controller. */
`timescale 1ns/100ps
`default_nettype none
module csc_osc_model
  import csc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // Enables and fault command
  input  wire csc_osc_t  oscEn,
  input  wire logic      failCmd,
  // Status back to the controller
  output csc_osc_t       oscStable,
  output logic           xoscFail,
  output logic           pllFail
);
  csc_osc_t d1_ff;
  csc_osc_t d2_ff;
  // Start-up delay of three cycles; a source drops out one cycle after it is disabled
  always_ff @(posedge clk)
  begin
    d1_ff     <= rst_n ? oscEn : '0;
    d2_ff     <= rst_n ? d1_ff : '0;
    oscStable <= rst_n ? (d2_ff & oscEn) : '0;
  end
  // Faults only on request and only on running sources
  assign xoscFail = failCmd & oscEn.xosc;
  assign pllFail  = failCmd & oscEn.pll;
endmodule // csc_osc_model
`default_nettype wire

// >>> bench/csc_chk_sva.sv
/* Port checker for the clock and sleep controller.
   Assumes sleepMode is held while the block sleeps. */
`timescale 1ns/100ps
`default_nettype none
module csc_chk
  import csc_pkg::*;
#(parameter int NPER = 8)
(
  // Clock and reset
  input wire logic            clk,
  input wire logic            rst_n,
  // Inputs watched
  input wire logic            sleepInstr,
  input wire logic            sleepEn,
  input wire csc_slp_t        sleepMode,
  input wire logic [NPER-1:0] powerReduce,
  input wire csc_osc_t        oscStable,
  // Outputs watched
  input wire csc_osc_t        oscEn,
  input wire csc_src_t        sysSrc,
  input wire logic [4:0]      pllFactorOut,
  input wire logic            calib2mOn,
  input wire logic            calib32mOn,
  input wire logic            nmiReq,
  input wire csc_gate_t       gate,
  input wire logic [NPER-1:0] perClkEn,
  input wire logic            cpuHalt,
  input wire logic            asleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  csc_osc_t stableDly_ff;
  // Last cycle's stability, indexed later by the new source
  always_ff @(posedge clk)
  begin
    stableDly_ff <= oscStable;
  end
  sequence s_halt4;
    cpuHalt [*4] ##1 !cpuHalt;
  endsequence
  sequence s_reduced;
    powerReduce[0] ##1 powerReduce[0];
  endsequence
  a_reset_osc_src: assert property (disable iff (1'b0) !rst_n |=>
    oscEn == OSC_RST && sysSrc == SRC_RC2M) else $error("reset clock state bad");
  a_reset_calib_off: assert property (disable iff (1'b0) !rst_n |=>
    !calib2mOn && !calib32mOn) else $error("calibrator on after reset");
  a_pll_factor_range: assert property (pllFactorOut >= 5'h01)
    else $error("multiplier factor zero");
  a_fail_fallback: assert property (nmiReq |-> sysSrc == SRC_RC2M)
    else $error("no fallback with nmi");
  a_sleep_entry: assert property (sleepInstr && sleepEn && !asleep && !cpuHalt
    |=> asleep && cpuHalt) else $error("sleep not entered");
  a_sleep_only_instr: assert property (!asleep && !(sleepInstr && sleepEn)
    |=> !asleep) else $error("sleep without instruction");
  a_wake_halt_four: assert property ($fell(asleep) && cpuHalt |-> s_halt4)
    else $error("halt after wake not four cycles");
  a_pdown_gates_off: assert property (asleep && sleepMode == SLP_PDOWN
    |-> gate == 4'h0) else $error("clock running in power-down");
  a_idle_gates: assert property (asleep && sleepMode == SLP_IDLE
    |-> !gate.cpu && gate.per) else $error("idle gating wrong");
  a_reduce_stops: assert property (s_reduced |-> !perClkEn[0])
    else $error("reduced peripheral still clocked");
  a_switch_stable: assert property ($changed(sysSrc) && sysSrc != SRC_RC2M
    |-> stableDly_ff[3'h5 - sysSrc]) else $error("switch to unstable source");
endmodule // csc_chk
bind csc_clock_sleep_ctrl csc_chk #(.NPER(NPER)) csc_chk_i (.clk, .rst_n, .sleepInstr,
  .sleepEn, .sleepMode, .powerReduce, .oscStable, .oscEn, .sysSrc, .pllFactorOut,
  .calib2mOn, .calib32mOn, .nmiReq, .gate, .perClkEn, .cpuHalt, .asleep);
`default_nettype wire

// >>> bench/csc_clock_sleep_ctrl_tb.sv
/* Self-checking bench for the clock and sleep controller.
   Assumes the oscillator model of csc_osc_model on the status side. */
`timescale 1ns/100ps
`default_nettype none
module csc_clock_sleep_ctrl_tb;
  import csc_pkg::*;
  logic clk, rst_n, calib2mEn, rtcEn, wdtEn, failMonEn, failCmd, xoscFail, pllFail;
  logic sleepInstr, sleepEn, lowDrainOn, calib2mOn, nmiReq, cpuHalt, asleep;
  logic calib32mEn, calibRefWatch, nvmBusy, calib32mOn, calibRefWatchOut;
  csc_rtc_t    rtcSrc, rtcSrcOut;
  logic [10:0] prescale, prescaleOut;
  logic [4:0]  pllFactor, pllFactorOut;
  logic [1:0]  xoscMode, xoscModeOut;
  logic [7:0]  cal32k, cal32m, cal32kOut, cal32mOut, powerReduce, perClkEn;
  csc_src_t    srcSel, sysSrc;
  csc_osc_t    oscEnReq, oscStable, oscEn;
  csc_slp_t    sleepMode;
  csc_wake_t   wakeReq;
  csc_gate_t   gate;
  int          err_total, checks;
  csc_clock_sleep_ctrl csc_clock_sleep_ctrl_i (.clk, .rst_n, .srcSel, .oscEnReq, .prescale,
    .pllFactor, .xoscMode, .cal32k, .cal32m, .calib2mEn, .calib32mEn,
    .calibRefWatch, .rtcSrc, .rtcEn, .wdtEn, .failMonEn, .oscStable,
    .xoscFail, .pllFail, .sleepInstr, .sleepEn, .sleepMode, .nvmBusy, .wakeReq,
    .powerReduce, .lowDrainOn, .oscEn, .sysSrc, .prescaleOut, .pllFactorOut, .xoscModeOut,
    .cal32kOut, .cal32mOut, .calib2mOn, .calib32mOn, .calibRefWatchOut, .rtcSrcOut,
    .nmiReq, .gate, .perClkEn, .cpuHalt, .asleep);
  csc_osc_model csc_osc_model_i (.clk, .rst_n, .oscEn, .failCmd, .oscStable, .xoscFail,
    .pllFail);
  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Clock edge then settle, so registered outputs are read after they land
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task give_up();
    err_total++;
    final_report();
  endtask
  task t_reset();
    chk("oscEn", 16'h20, oscEn);
    chk("sysSrc", SRC_RC2M, sysSrc);
    chk("calib2mOn", 0, calib2mOn);
    chk("lowDrainOn", 0, lowDrainOn);
    chk("pllFactorOut", 1, pllFactorOut);
    chk("calib32mOn", 0, calib32mOn);
    chk("cpuHalt", 0, cpuHalt);
    @(posedge clk);
    wdtEn <= 1'b1;
    calib2mEn <= 1'b1;
    tick(1);
    chk("lowDrainOn", 1, lowDrainOn);
    chk("calib2mOn", 1, calib2mOn);
  endtask
  task t_settings();
    @(posedge clk);
    prescale <= 11'h7FF;
    xoscMode <= 2'h3;
    cal32k <= 8'h3C;
    cal32m <= 8'hC3;
    powerReduce <= 8'h05;
    calib32mEn <= 1'b1;
    calibRefWatch <= 1'b1;
    rtcSrc <= RTC_WXTAL;
    wdtEn <= 1'b0;
    tick(2);
    chk("calib32mOn", 1, calib32mOn);
    chk("calibRefWatchOut", 1, calibRefWatchOut);
    chk("rtcSrcOut", RTC_WXTAL, rtcSrcOut);
    chk("lowDrainOn", 0, lowDrainOn);
    chk("prescaleOut", 16'h7FF, prescaleOut);
    chk("xoscModeOut", 3, xoscModeOut);
    chk("cal32kOut", 16'h3C, cal32kOut);
    chk("cal32mOut", 16'hC3, cal32mOut);
    chk("pllFactorOut", 1, pllFactorOut);
    chk("perClkEn", 16'hFA, perClkEn);
    @(posedge clk);
    pllFactor <= 5'h1F;
    powerReduce <= 8'h00;
    rtcSrc <= RTC_LDRAIN;
    rtcEn <= 1'b1;
    tick(2);
    chk("lowDrainOn", 1, lowDrainOn);
    chk("pllFactorOut", 16'h1F, pllFactorOut);
    chk("perClkEn", 16'hFF, perClkEn);
  endtask
  task t_switch_fail(input csc_src_t s, input csc_osc_t en);
    int n;
    @(posedge clk);
    oscEnReq <= en;
    srcSel <= s;
    tick(2);
    chk("sysSrc", SRC_RC2M, sysSrc);
    for (n = 0; n < 20 && sysSrc !== s; n++) tick(1);
    if (n == 20) give_up();
    chk("sysSrc", s, sysSrc);
    @(posedge clk);
    failMonEn <= 1'b1;
    failCmd <= 1'b1;
    for (n = 0; n < 20 && nmiReq !== 1'b1; n++) tick(1);
    if (n == 20) give_up();
    chk("sysSrc", SRC_RC2M, sysSrc);
    tick(5);
    chk("sysSrc", SRC_RC2M, sysSrc);
    chk("nmiReq", 0, nmiReq);
    @(posedge clk);
    failCmd <= 1'b0;
    failMonEn <= 1'b0;
    srcSel <= SRC_RC2M;
  endtask
  task t_sleep(input csc_slp_t m, input logic [3:0] ge, input csc_wake_t w,
    input csc_wake_t nw);
    int n;
    @(posedge clk);
    sleepMode <= m;
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    tick(1);
    chk("asleep", 1, asleep);
    chk("gate", ge, gate);
    chk("perClkEn", (m == SLP_IDLE) ? 16'hFF : 16'h00, perClkEn);
    if (m != SLP_IDLE) chk("oscEn", (m >= SLP_STDBY) ? oscEnReq : 6'h00, oscEn);
    @(posedge clk);
    wakeReq <= nw;
    nvmBusy <= 1'b0;
    tick(6);
    chk("asleep", 1, asleep);
    chk("gateNvm", 0, gate.nvm);
    @(posedge clk);
    wakeReq <= w;
    for (n = 0; n < 20 && asleep === 1'b1; n++) tick(1);
    if (n == 20) give_up();
    for (n = 0; n < 9 && cpuHalt === 1'b1; n++) tick(1);
    chk("haltCycles", 4, n);
    @(posedge clk);
    wakeReq <= '0;
  endtask
  task t_reset_in_sleep();
    @(posedge clk);
    sleepMode <= SLP_PDOWN;
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("asleep", 0, asleep);
    chk("oscEn", 16'h20, oscEn);
  endtask
  // Main sequence: reset held four cycles, then each scenario in turn
  initial
  begin
    {rst_n, calib2mEn, rtcEn, wdtEn, failMonEn, failCmd, sleepInstr, sleepEn} = '0;
    {calib32mEn, calibRefWatch, nvmBusy} = '0;
    rtcSrc = RTC_LDRAIN;
    {prescale, pllFactor, xoscMode, cal32k, cal32m, powerReduce} = '0;
    srcSel = SRC_RC2M;
    oscEnReq = 6'h20;
    sleepMode = SLP_IDLE;
    wakeReq = '0;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_settings();
    t_switch_fail(SRC_XOSC, 6'h24);
    t_switch_fail(SRC_PLL, 6'h22);
    @(posedge clk);
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    sleepEn <= 1'b1;
    nvmBusy <= 1'b1;
    rtcEn <= 1'b1;
    tick(2);
    chk("asleep", 0, asleep);
    t_sleep(SLP_IDLE, 4'h7, 5'h10, 5'h00);
    t_sleep(SLP_PDOWN, 4'h0, 5'h08, 5'h01);
    t_sleep(SLP_PSAVE, 4'h1, 5'h01, 5'h10);
    t_sleep(SLP_STDBY, 4'h0, 5'h04, 5'h01);
    t_sleep(SLP_ESTBY, 4'h1, 5'h02, 5'h10);
    t_reset_in_sleep();
    final_report();
  end
endmodule // csc_clock_sleep_ctrl_tb
`default_nettype wire
